/* File: rtl/hdlc_sync_framer.sv */
// HDLC framer for one serial channel: AXI4-Lite registers, transmit framing, receive deframing.
// Assumes link inputs are asynchronous to ref_clk and a receive clock well below ref_clk / 4.
// What this block does, and what it expects of the host and the far end
// R01: A received character enters the receive CRC only while receive CRC enable is set.
// R02: CRC error status reflects the check 16 bit times after a character is buffered.
// R03: Far end keeps receive clock running 16 bit times after the last CRC byte.
// R04: Flags delimit every frame, both sent and detected.
// R05: Received flags never reach the buffer; control field passes as plain data.
// R06: With address search on, frames whose address differs from the station address are dropped.
// R07: Transmit CRC presets to ones by command; receive CRC restarts on an opening flag.
// R08: Receive character length comes from bits 7:6: 00=5, 01=7, 10=6, 11=8.
// R09: HDLC operation is selected by mode field bits 5:4 equal to 10.
// R10: Polynomial select zero gives the CCITT polynomial x16+x12+x5+1.
// R11: With transmit enabled, flags go out until the first data byte is written.
// R12: Host should let at least two flags out before its first write.
// R13: Enabling the transmitter with an empty buffer raises no transmit request.
// R14: With bit 6 of interrupt control set, a loaded flag raises the transmit request.
// R15: In auto enable mode, sending starts only once clear-to-send is active.
// R16: Characters go out LSB first with the transmit length from bits 6:5.
// R17: Transmit length is applied when the character moves into the shifter.
// R18: Enhanced variant presets the transmit CRC whenever a flag is loaded.
// R19: On underrun CRC is appended only if end-of-message is zero.
// R20: With length check on, underrun sends CRC on count match, abort otherwise.
// R21: A zero is inserted after five ones in frame content; receiver removes it.
// R22: Transmit buffer empty shows in status bit 2; host writes only while set.
// R23: Receiver drops a zero after five ones and takes 01111110 as a flag.
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "hdlc_framer_defs.svh"
module hdlc_sync_framer #(
	parameter int TX_DIV = `TX_BIT_NS / `CLK_PERIOD_NS,
	parameter bit ENHANCED = 1'b1,
	parameter int LEN_W = 16
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire hdlc_pkg::link_in_s link_in,
	output logic txd,
	output logic dma_request
);
	import hdlc_pkg::*;

	function automatic logic [15:0] crc_char(input logic [15:0] crc, input logic [7:0] d,
		input logic [3:0] len, input logic [15:0] poly);
		logic [15:0] c;
		logic fb;
		c = crc;
		for (int i = 0; i < 8; i++) begin
			fb = c[0] ^ d[i];
			if (i < int'(len)) begin
				c = (c >> 1) ^ (fb ? poly : 16'h0000);
			end
		end
		return c;
	endfunction

	function automatic logic [3:0] char_len(input logic [1:0] code);
		return (code == 2'b00) ? 4'h5 : (code == 2'b01) ? 4'h7 : (code == 2'b10) ? 4'h6 : 4'h8;
	endfunction

	logic [7:0] interrupt_control_reg;
	logic [7:0] receive_control_reg;
	logic [7:0] mode_select_reg;
	logic [7:0] transmit_control_reg;
	logic [7:0] sync_low_address_reg;
	logic [7:0] sync_high_flag_reg;
	logic [LEN_W-1:0] tx_length;
	logic [LEN_W-1:0] tx_count;

	// Bus slave state
	logic aw_have;
	logic w_have;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] rd_value;
	logic rd_hit;

	// Link synchroniser; only the second stage is read by logic
	link_in_s link_meta;
	link_in_s link_sync;
	logic rx_clock_last;

	// Receive path
	rx_state_e rx_state;
	logic [7:0] rx_raw;
	logic [2:0] rx_ones;
	logic [6:0] rx_delay;
	logic [2:0] rx_dcount;
	logic [7:0] rx_char;
	logic [3:0] rx_ccount;
	logic [15:0] rx_crc;
	logic rx_crc_restart;
	logic rx_pending;
	logic [4:0] crc_wait;
	logic crc_err;
	logic [7:0] rx_data_reg;
	logic rx_avail;

	// Transmit path
	tx_state_e tx_state;
	logic [$clog2(TX_DIV+1)-1:0] tx_div_cnt;
	logic [15:0] tx_shift;
	logic [4:0] tx_left;
	logic tx_stuff;
	logic [2:0] tx_ones;
	logic [15:0] tx_crc;
	logic [7:0] tx_buf;
	logic tx_full;
	logic end_of_message;
	logic abort_req;
	logic req_armed;

	// Register decode
	wire write_fire = aw_have & w_have & ~bvalid;
	wire lane0 = write_fire & wr_strb[0];
	wire wr_tx_data = lane0 & (wr_addr == `OFS_TX_DATA);
	wire wr_command = lane0 & (wr_addr == `OFS_COMMAND);
	wire cmd_crc_preset = wr_command & wr_data[`CMD_CRC_PRESET];
	wire cmd_eom_reset = wr_command & wr_data[`CMD_EOM_RESET];
	wire cmd_abort = wr_command & wr_data[`CMD_ABORT];
	wire wr_known = (wr_addr <= `OFS_TX_LENGTH) & (wr_addr[1:0] == 2'b00) &
		(wr_addr != `OFS_MAIN_STAT) & (wr_addr != `OFS_RX_STAT) & (wr_addr != `OFS_RX_DATA);
	wire read_fire = arvalid & arready;
	wire rd_rx_data = read_fire & (araddr == `OFS_RX_DATA);

	wire hdlc_mode = mode_select_reg[`MS_SYNC_HI:`MS_SYNC_LO] == `SYNC_HDLC; // R09
	wire [15:0] crc_poly = transmit_control_reg[`TC_POLY] ? `POLY_CRC16 : `POLY_CCITT; // R10
	wire [3:0] rx_len = char_len(receive_control_reg[`RC_LEN_HI:`RC_LEN_LO]); // R08
	wire [3:0] tx_len = char_len(transmit_control_reg[`TC_LEN_HI:`TC_LEN_LO]); // R16
	wire [7:0] main_status = {1'b0, end_of_message, 3'b000, ~tx_full, 1'b0, rx_avail}; // R22
	wire [7:0] rx_status = {1'b0, crc_err, 6'b000000};

	assign rd_hit = (araddr[1:0] == 2'b00) & (araddr <= `OFS_TX_COUNT) & (araddr != `OFS_TX_DATA) &
		(araddr != `OFS_COMMAND);
	assign rd_value =
		(araddr == `OFS_INT_CTRL) ? {24'h000000, interrupt_control_reg} :
		(araddr == `OFS_RX_CTRL) ? {24'h000000, receive_control_reg} :
		(araddr == `OFS_MODE) ? {24'h000000, mode_select_reg} :
		(araddr == `OFS_TX_CTRL) ? {24'h000000, transmit_control_reg} :
		(araddr == `OFS_SYNC_LOW) ? {24'h000000, sync_low_address_reg} :
		(araddr == `OFS_SYNC_HIGH) ? {24'h000000, sync_high_flag_reg} :
		(araddr == `OFS_MAIN_STAT) ? {24'h000000, main_status} :
		(araddr == `OFS_RX_STAT) ? {24'h000000, rx_status} :
		(araddr == `OFS_RX_DATA) ? {24'h000000, rx_data_reg} :
		(araddr == `OFS_TX_LENGTH) ? 32'(tx_length) :
		(araddr == `OFS_TX_COUNT) ? 32'(tx_count) : 32'h00000000;

	// Write channel: address and data accepted in either order, response after both
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `AXI_OKAY;
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_have <= 1'b1;
				awready <= 1'b0;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_have <= 1'b1;
				wready <= 1'b0;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (write_fire) begin
				bvalid <= 1'b1;
				bresp <= wr_known ? `AXI_OKAY : `AXI_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				aw_have <= 1'b0;
				w_have <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// Read channel: one cycle from address to data
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `AXI_OKAY;
		end else if (read_fire) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_hit ? rd_value : 32'h00000000;
			rresp <= rd_hit ? `AXI_OKAY : `AXI_SLVERR;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			interrupt_control_reg <= `REG_RESET;
			receive_control_reg <= `REG_RESET;
			mode_select_reg <= `REG_RESET;
			transmit_control_reg <= `REG_RESET;
			sync_low_address_reg <= `REG_RESET;
			sync_high_flag_reg <= `FLAG_PATTERN;
			tx_length <= '0;
		end else if (lane0) begin
			if (wr_addr == `OFS_INT_CTRL) interrupt_control_reg <= wr_data[7:0];
			if (wr_addr == `OFS_RX_CTRL) receive_control_reg <= wr_data[7:0];
			if (wr_addr == `OFS_MODE) mode_select_reg <= wr_data[7:0];
			if (wr_addr == `OFS_TX_CTRL) transmit_control_reg <= wr_data[7:0];
			if (wr_addr == `OFS_SYNC_LOW) sync_low_address_reg <= wr_data[7:0];
			if (wr_addr == `OFS_SYNC_HIGH) sync_high_flag_reg <= wr_data[7:0];
			if (wr_addr == `OFS_TX_LENGTH) tx_length <= wr_data[LEN_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			link_meta <= '{serial_rx_clock: 1'b0, rx_data: 1'b1, cts_n: 1'b1};
			link_sync <= '{serial_rx_clock: 1'b0, rx_data: 1'b1, cts_n: 1'b1};
			rx_clock_last <= 1'b0;
		end else begin
			link_meta <= link_in;
			link_sync <= link_meta;
			rx_clock_last <= link_sync.serial_rx_clock;
		end
	end

	// Receive: flags are seen on the raw line; data is destuffed, then delayed seven bits
	// so a flag's own bits are discarded before they could reach a character.
	wire rx_tick = link_sync.serial_rx_clock & ~rx_clock_last;
	wire rx_bit = link_sync.rx_data;
	wire [7:0] rx_raw_next = {rx_bit, rx_raw[7:1]};
	wire rx_flag = rx_raw_next == `FLAG_PATTERN; // R23
	wire rx_stuffed = ~rx_bit & (rx_ones == `STUFF_RUN); // R21
	wire rx_abort = rx_bit & (rx_ones == `ABORT_RUN);
	wire rx_out_valid = rx_dcount == `RX_DELAY_BITS;
	wire rx_active = (rx_state == RX_ADDR) | (rx_state == RX_DATA);
	wire [7:0] rx_char_next = {rx_delay[0], rx_char[7:1]};
	wire [7:0] rx_value = rx_char_next >> (4'h8 - rx_len);
	wire rx_char_done = rx_tick & rx_active & rx_out_valid & ~rx_flag & ~rx_abort & ~rx_stuffed &
		(rx_ccount + 4'h1 == rx_len);
	wire rx_addr_miss = (rx_state == RX_ADDR) & receive_control_reg[`RC_ADDR_SRCH] &
		(rx_value != sync_low_address_reg);
	wire rx_deliver = rx_char_done & ~rx_addr_miss;
	wire rx_crc_take = rx_pending & receive_control_reg[`RC_CRC_EN];
	wire [15:0] rx_crc_check = rx_crc_take ? crc_char(rx_crc, rx_data_reg, rx_len, crc_poly) : rx_crc;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rx_state <= RX_HUNT;
			rx_raw <= 8'h00;
			rx_ones <= 3'd0;
			rx_delay <= 7'h00;
			rx_dcount <= 3'd0;
			rx_char <= 8'h00;
			rx_ccount <= 4'h0;
		end else if (rx_tick) begin
			rx_raw <= rx_raw_next;
			rx_ones <= !rx_bit ? 3'd0 : (rx_ones == `ONES_MAX) ? `ONES_MAX : rx_ones + 3'd1;
			if (!receive_control_reg[`RC_RX_EN] || !hdlc_mode) begin
				rx_state <= RX_HUNT;
				rx_dcount <= 3'd0;
			end else if (rx_flag) begin
				rx_state <= RX_ADDR; // R04
				rx_dcount <= 3'd0; // R05
				rx_ccount <= 4'h0;
			end else if (rx_abort) begin
				rx_state <= RX_HUNT;
				rx_dcount <= 3'd0;
			end else if (!rx_stuffed) begin
				rx_delay <= {rx_bit, rx_delay[6:1]};
				if (!rx_out_valid) rx_dcount <= rx_dcount + 3'd1;
				if (rx_out_valid && rx_active) begin
					rx_char <= rx_char_next;
					rx_ccount <= rx_char_done ? 4'h0 : rx_ccount + 4'h1;
				end
				if (rx_char_done) rx_state <= rx_addr_miss ? RX_SKIP : RX_DATA; // R06
			end
		end
	end

	// Receive CRC: a buffered character is folded in at the next load, or at the check,
	// so the host may still decide on it while it sits in the buffer.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			rx_crc <= `CRC_PRESET;
			rx_crc_restart <= 1'b1;
			rx_pending <= 1'b0;
			crc_wait <= 5'd0;
			crc_err <= 1'b0;
			rx_data_reg <= 8'h00;
		end else begin
			if (rx_tick && rx_flag) rx_crc_restart <= 1'b1; // R07
			if (rx_tick && crc_wait != 5'd0) crc_wait <= crc_wait - 5'd1;
			if (rx_tick && crc_wait == 5'd1) crc_err <= rx_crc_check != `CRC_GOOD; // R02
			if (rx_deliver) begin
				rx_data_reg <= rx_value;
				rx_pending <= 1'b1;
				crc_wait <= `CRC_CHECK_BITS; // R02
				if (rx_crc_restart || (rx_tick && rx_flag)) begin
					rx_crc <= `CRC_PRESET; // R07
					rx_crc_restart <= 1'b0;
				end else if (rx_crc_take) begin
					rx_crc <= rx_crc_check; // R01
				end
			end
		end
	end

	// New character wins over a simultaneous read of the data register
	always_ff @(posedge ref_clk) begin
		if (!nrst) rx_avail <= 1'b0;
		else if (rx_deliver) rx_avail <= 1'b1;
		else if (rd_rx_data) rx_avail <= 1'b0;
	end

	// Transmit bit rate enable
	wire tx_tick = tx_div_cnt == '0;
	always_ff @(posedge ref_clk) begin
		if (!nrst) tx_div_cnt <= '0;
		else tx_div_cnt <= tx_tick ? ($bits(tx_div_cnt))'(TX_DIV - 1) : tx_div_cnt - 1'b1;
	end

	// Transmit element selection when the shifter runs empty
	wire tx_en = transmit_control_reg[`TC_TX_EN] & hdlc_mode;
	wire cts_ok = ~receive_control_reg[`RC_AUTO_EN] | ~link_sync.cts_n; // R15
	wire stuff_due = tx_stuff & (tx_ones == `STUFF_RUN); // R21
	wire need_load = (tx_left == 5'd0) & ~stuff_due;
	wire len_bad = interrupt_control_reg[`IC_TXLEN_BIT] & (tx_count != tx_length); // R20
	logic [15:0] ld_shift;
	logic [4:0] ld_left;
	logic ld_stuff;
	tx_state_e ld_state;
	logic flag_load;
	logic data_load;
	logic underrun;

	always_comb begin
		ld_shift = {8'h00, `FLAG_PATTERN};
		ld_left = `FLAG_BITS;
		ld_stuff = 1'b0;
		ld_state = TX_FLAG;
		flag_load = 1'b0;
		data_load = 1'b0;
		underrun = 1'b0;
		if (!cts_ok && (tx_state == TX_IDLE)) begin
			ld_shift = `IDLE_WORD;
			ld_left = 5'd1;
			ld_state = TX_IDLE;
		end else if (abort_req) begin
			ld_shift = `ABORT_WORD;
			ld_left = `ABORT_BITS;
			ld_state = TX_ABORT;
		end else if (tx_full && tx_state != TX_CRC) begin
			ld_shift = {8'h00, tx_buf}; // R16
			ld_left = {1'b0, tx_len}; // R17
			ld_stuff = 1'b1;
			ld_state = TX_DATA;
			data_load = 1'b1;
		end else if (tx_state == TX_DATA && !end_of_message) begin // R19
			underrun = 1'b1;
			if (len_bad) begin
				ld_shift = `ABORT_WORD; // R20
				ld_left = `ABORT_BITS;
				ld_state = TX_ABORT;
			end else begin
				ld_shift = ~tx_crc;
				ld_left = `CRC_BITS;
				ld_stuff = 1'b1;
				ld_state = TX_CRC;
			end
		end else begin
			underrun = tx_state == TX_DATA;
			flag_load = 1'b1; // R04 R11
		end
	end

	wire [15:0] cur_shift = need_load ? ld_shift : tx_shift;
	wire [4:0] cur_left = need_load ? ld_left : tx_left;
	wire tx_go = tx_tick & tx_en;
	wire tx_write_ok = wr_tx_data & ~tx_full; // R22

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			tx_state <= TX_IDLE;
			tx_shift <= `IDLE_WORD;
			tx_left <= 5'd0;
			tx_stuff <= 1'b0;
			tx_ones <= 3'd0;
			txd <= 1'b1;
		end else if (tx_tick && !tx_en) begin
			tx_state <= TX_IDLE;
			tx_left <= 5'd0;
			tx_stuff <= 1'b0;
			tx_ones <= 3'd0;
			txd <= 1'b1;
		end else if (tx_go && stuff_due) begin
			txd <= 1'b0; // R21
			tx_ones <= 3'd0;
		end else if (tx_go) begin
			if (need_load) begin
				tx_state <= ld_state;
				tx_stuff <= ld_stuff;
			end
			txd <= cur_shift[0]; // R16
			tx_shift <= cur_shift >> 1;
			tx_left <= cur_left - 5'd1;
			tx_ones <= !cur_shift[0] ? 3'd0 : (tx_ones == `ONES_MAX) ? `ONES_MAX : tx_ones + 3'd1;
		end
	end

	wire ld_now = tx_go & need_load;
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			tx_crc <= `CRC_PRESET;
			tx_buf <= 8'h00;
			tx_full <= 1'b0;
			end_of_message <= 1'b1;
			abort_req <= 1'b0;
			tx_count <= '0;
		end else begin
			if (tx_write_ok) tx_buf <= wdata_byte(wr_data);
			if (cmd_crc_preset || (ENHANCED && ld_now && flag_load)) tx_crc <= `CRC_PRESET; // R07 R18
			if (ld_now && flag_load) tx_count <= '0;
			if (cmd_abort) abort_req <= 1'b1;
			if (ld_now && ld_state == TX_ABORT && abort_req) abort_req <= 1'b0;
			if (cmd_eom_reset) end_of_message <= 1'b0; // R19
			if (ld_now && data_load) begin
				if (transmit_control_reg[`TC_CRC_EN]) tx_crc <= crc_char(tx_crc, tx_buf, tx_len, crc_poly);
				tx_count <= tx_count + 1'b1;
				if (ENHANCED) end_of_message <= 1'b0; // R19
			end
			if (ld_now && underrun) end_of_message <= 1'b1;
			if (tx_write_ok) tx_full <= 1'b1;
			else if ((ld_now && data_load) || cmd_abort) tx_full <= 1'b0;
		end
	end

	function automatic logic [7:0] wdata_byte(input logic [31:0] w);
		return w[7:0];
	endfunction

	// Request is held back until the first write, or a flag load when the option is set
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			req_armed <= 1'b0;
			dma_request <= 1'b0;
		end else begin
			if (!tx_en) req_armed <= 1'b0; // R13
			else if (tx_write_ok) req_armed <= 1'b1;
			else if (ld_now && flag_load && interrupt_control_reg[`IC_TXLEN_BIT]) req_armed <= 1'b1; // R14
			dma_request <= tx_en & req_armed & ~tx_full & ~tx_write_ok;
		end
	end
endmodule // hdlc_sync_framer

/* File: rtl/hdlc_framer_defs.svh */
// Constants for the HDLC framer: register offsets, field positions, reset values, timing.
// Assumes a 40 MHz reference clock and byte addresses on a 32-bit AXI4-Lite register bus.
`ifndef HDLC_FRAMER_DEFS_SVH
`define HDLC_FRAMER_DEFS_SVH
`define CLK_PERIOD_NS 25
`define TX_BIT_NS 200
`define OFS_INT_CTRL 8'h00
`define OFS_RX_CTRL 8'h04
`define OFS_MODE 8'h08
`define OFS_TX_CTRL 8'h0c
`define OFS_SYNC_LOW 8'h10
`define OFS_SYNC_HIGH 8'h14
`define OFS_MAIN_STAT 8'h18
`define OFS_RX_STAT 8'h1c
`define OFS_TX_DATA 8'h20
`define OFS_RX_DATA 8'h24
`define OFS_COMMAND 8'h28
`define OFS_TX_LENGTH 8'h2c
`define OFS_TX_COUNT 8'h30
`define IC_TXLEN_BIT 6
`define RC_LEN_HI 7
`define RC_LEN_LO 6
`define RC_AUTO_EN 5
`define RC_CRC_EN 3
`define RC_ADDR_SRCH 2
`define RC_RX_EN 0
`define MS_SYNC_HI 5
`define MS_SYNC_LO 4
`define SYNC_HDLC 2'b10
`define TC_LEN_HI 6
`define TC_LEN_LO 5
`define TC_TX_EN 3
`define TC_POLY 2
`define TC_CRC_EN 0
`define ST_RX_AVAIL 0
`define ST_TBE 2
`define ST_EOM 6
`define RS_CRC_ERR 6
`define CMD_CRC_PRESET 0
`define CMD_EOM_RESET 1
`define CMD_ABORT 2
`define REG_RESET 8'h00
`define FLAG_PATTERN 8'h7e
`define CRC_PRESET 16'hffff
`define CRC_GOOD 16'hf0b8
`define POLY_CCITT 16'h8408
`define POLY_CRC16 16'ha001
`define FLAG_BITS 5'd8
`define ABORT_BITS 5'd8
`define CRC_BITS 5'd16
`define ABORT_WORD 16'h00ff
`define IDLE_WORD 16'hffff
`define STUFF_RUN 3'd5
`define ABORT_RUN 3'd6
`define ONES_MAX 3'd7
`define RX_DELAY_BITS 3'd7
`define CRC_CHECK_BITS 5'd16
`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10
`endif

/* File: rtl/hdlc_pkg.sv */
// Types shared by the HDLC framer: state encodings and the serial link input bundle.
// Assumes the constants header is on the include path.
package hdlc_pkg;
	typedef enum logic [2:0] {
		TX_IDLE = 3'b000,
		TX_FLAG = 3'b001,
		TX_DATA = 3'b010,
		TX_CRC = 3'b011,
		TX_ABORT = 3'b100
	} tx_state_e;
	typedef enum logic [1:0] {
		RX_HUNT = 2'b00,
		RX_ADDR = 2'b01,
		RX_DATA = 2'b10,
		RX_SKIP = 2'b11
	} rx_state_e;
	typedef struct packed {
		logic serial_rx_clock;
		logic rx_data;
		logic cts_n;
	} link_in_s;
endpackage

/* File: bench/hdlc_sync_framer_props.sv */
// Port checker for the HDLC framer: bus handshakes and serial bit timing.
// Assumes the master offers write address and write data in the same cycle.
`timescale 1ns/1ps
module hdlc_sync_framer_props #(
	parameter int TX_DIV = 8
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic txd,
	input wire logic dma_request
);
	logic [4:0] run;
	logic prev;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Run length saturates so long idle stretches cannot wrap round
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			run <= 5'd31;
			prev <= 1'b1;
		end else begin
			prev <= txd;
			run <= (txd != prev) ? 5'd0 : ((run == 5'd31) ? run : run + 5'd1);
		end
	end
	a_reset_quiet: assert property ($rose(nrst) |-> txd && !dma_request && !bvalid && !rvalid)
		else $error("outputs not idle after reset");
	a_read_latency: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	a_rd_release: assert property (rvalid && rready |=> !rvalid && arready)
		else $error("read channel not released");
	a_write_latency: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
		else $error("write answer late");
	a_aw_busy: assert property (awvalid && awready |=> !awready)
		else $error("write address taken twice");
	a_wr_release: assert property (bvalid && bready |=> !bvalid && awready && wready)
		else $error("write channel not released");
	a_bad_write: assert property (awvalid && awready && awaddr > 8'h30 |-> ##[1:3] (bvalid && bresp == 2'b10))
		else $error("unmapped write not refused");
	a_bad_read: assert property (arvalid && arready && araddr > 8'h30 |=> rresp == 2'b10 && rdata == 32'h0)
		else $error("unmapped read not refused");
	a_bit_time: assert property (txd != prev |-> run >= TX_DIV - 1)
		else $error("serial bit too short");
endmodule // hdlc_sync_framer_props
bind hdlc_sync_framer hdlc_sync_framer_props #(.TX_DIV(TX_DIV)) props (.*);

/* File: bench/hdlc_station_model.sv */
// Far-side station: sends HDLC frames on the receive lines.
// Assumes the bench calls send_frame; the receive clock stands still between frames.
`timescale 1ns/1ps
module hdlc_station_model (
	output hdlc_pkg::link_in_s link
);
	import hdlc_pkg::*;
	logic [15:0] crc;
	int ones;
	initial link = '{serial_rx_clock: 1'b0, rx_data: 1'b1, cts_n: 1'b0};
	task automatic put_bit(input logic b);
		link.rx_data = b;
		#100 link.serial_rx_clock = 1'b1;
		#100 link.serial_rx_clock = 1'b0;
	endtask
	task automatic send_bit(input logic b);
		crc = (crc >> 1) ^ ((crc[0] ^ b) ? 16'h8408 : 16'h0);
		put_bit(b);
		ones = b ? ones + 1 : 0;
		if (ones == 5) begin
			put_bit(1'b0);
			ones = 0;
		end
	endtask
	task automatic set_cts(input logic n);
		link.cts_n = n;
	endtask
	task automatic flag;
		for (int i = 0; i < 8; i++) put_bit(i != 0 && i != 7);
	endtask
	// A bad frame flips one check bit, on the bench's request only
	task automatic send_frame(input logic [7:0] q[$], input bit bad);
		logic [15:0] fcs;
		crc = 16'hffff;
		ones = 0;
		flag();
		foreach (q[i]) for (int j = 0; j < 8; j++) send_bit(q[i][j]);
		fcs = ~crc ^ {15'h0, bad};
		for (int j = 0; j < 16; j++) send_bit(fcs[j]);
		repeat (4) flag();
		link.rx_data = ~link.rx_data;
	endtask
endmodule // hdlc_station_model

/* File: bench/tb_hdlc_sync_framer.sv */
// Self-checking bench for the HDLC framer: registers, receive frames, transmit frames.
// Assumes the station model and the bound checker; TX_DIV stays at 8.
`timescale 1ns/1ps
module tb_hdlc_sync_framer;
	import hdlc_pkg::*;
	logic ref_clk, nrst, awvalid, wvalid, bready, arvalid, rready, dmax, sb;
	logic awready, wready, bvalid, arready, rvalid, txd, dma_request;
	logic [7:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [31:0] wdata, rdata, rv;
	logic [1:0] bresp, rresp;
	link_in_s link;
	logic [33:0] eq[$], mq[$], fq[$];
	logic [7:0] pay[$];
	logic bits[$];
	int n_mismatch, n_checks, seed, ph, ones, nflag;
	hdlc_sync_framer uut (.*, .link_in(link));
	hdlc_station_model far (.link(link));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	function automatic void chk(input logic [33:0] g, e, m);
		n_checks++;
		if ((g & m) !== (e & m)) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h want %h", $time, g, e);
		end
	endfunction
	always @(posedge ref_clk) begin
		if (rvalid && rready) begin
			if (mq[0] != 0) chk({rresp, rdata}, eq[0], mq[0]);
			eq.delete(0);
			mq.delete(0);
		end
	end
	function automatic void res(input bit ab);
		logic [15:0] c;
		int n;
		c = 16'hffff;
		n = bits.size() - 7;
		for (int i = 0; i < n; i++) c = (c >> 1) ^ ((c[0] ^ bits[i]) ? 16'h8408 : 16'h0);
		if (fq.size() > 0) chk(ab ? 34'h0 : {2'b0, n[15:0], c}, fq.pop_front(), '1);
	endfunction
	// Serial decoder: samples mid-bit, strips stuffed zeros, reports frames and aborts
	always @(posedge ref_clk) begin
		ph = (txd != sb) ? 0 : (ph + 1) % 8;
		sb = txd;
		if (ph == 4) begin
			if (txd) begin
				ones++;
				bits.push_back(1'b1);
				if (ones == 7 && bits.size() > 12) res(1'b1);
				if (ones >= 7) bits.delete();
			end else begin
				if (ones == 6) nflag++;
				if (ones == 6 && bits.size() > 7) res(1'b0);
				if (ones >= 6) bits.delete();
				else if (ones != 5) bits.push_back(1'b0);
				ones = 0;
			end
		end
	end
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= {16'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e, m);
		eq.push_back(e);
		mq.push_back(m);
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rv = rdata;
				rready <= 1'b0;
				break;
			end
		end
	endtask
	task automatic poll(input int b);
		do rd(8'h18, 34'h0, 34'h0); while (rv[b] !== 1'b1);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#1000000;
		n_mismatch++;
		give_verdict();
	end
	initial begin
		seed = 32'haa77;
		nrst = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		awaddr = 8'h0;
		araddr = 8'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(8'h18, 34'h4, 34'h4);
		rd(8'h40, 34'h200000000, '1);
		wr(8'h40, 16'h1);
		wr(8'h08, 16'h20);
		wr(8'h10, 16'h5a);
		wr(8'h04, 16'hcd);
		// Frame 0 misses the station address, frame 2 carries a bad check
		for (int i = 0; i < 4; i++) begin
			pay = {i ? 8'h5a : 8'h33, 8'h7e, 8'($random(seed)), 8'hff};
			fork
				far.send_frame(pay, i == 2);
				for (int k = 0; k < 6 && i > 0; k++) begin
					poll(0);
					rd(8'h24, k < 4 ? 34'(pay[k]) : 34'h0, k < 4 ? 34'hff : 34'h0);
				end
			join
			if (i == 0) rd(8'h18, 34'h0, 34'h1);
			else rd(8'h1c, 34'(i == 2) << 6, 34'h40);
		end
		wr(8'h0c, 16'h69);
		nflag = 0;
		dmax = 1'b0;
		repeat (320) @(posedge ref_clk) dmax = dmax | dma_request;
		chk(34'(dmax), 34'h0, '1);
		chk(34'(nflag >= 2), 34'h1, '1);
		wr(8'h0c, 16'h0);
		wr(8'h00, 16'h40);
		wr(8'h0c, 16'h69);
		for (int t = 0; t < 400 && dma_request !== 1'b1; t++) @(posedge ref_clk);
		chk(34'(dma_request), 34'h1, 34'h1);
		// Let two flags out before the first data write so the far receiver can lock
		repeat (160) @(posedge ref_clk);
		// Two bytes each: length 2 closes with a check, length 3 with an abort
		for (int f = 0; f < 2; f++) begin
			wr(8'h2c, f ? 16'h3 : 16'h2);
			fq.push_back(f ? 34'h0 : {2'b0, 16'd32, 16'hf0b8});
			wr(8'h20, 16'hff);
			poll(2);
			wr(8'h20, 16'($random(seed)) & 16'hff);
			for (int t = 0; t < 3000 && fq.size() > 0; t++) @(posedge ref_clk);
		end
		chk(34'(fq.size()), 34'h0, '1);
		rd(8'h18, 34'h44, 34'h44);
		// Auto enable: line idles while clear-to-send is inactive, flags once it goes active
		wr(8'h0c, 16'h0);
		wr(8'h04, 16'hed);
		far.set_cts(1'b1);
		wr(8'h0c, 16'h69);
		nflag = 0;
		repeat (200) @(posedge ref_clk);
		chk(34'(nflag), 34'h0, '1);
		far.set_cts(1'b0);
		repeat (200) @(posedge ref_clk);
		chk(34'(nflag >= 2), 34'h1, '1);
		give_verdict();
	end
endmodule // tb_hdlc_sync_framer
